// ---- logic/eag_consts.svh ----
`ifndef EAG_CONSTS_SVH
`define EAG_CONSTS_SVH

`define EAG_WORD_W       32
`define EAG_HALF_W       16
`define EAG_BYTE_W       8
`define EAG_PC_BASE_OFS  32'h0000_0002
`define EAG_STEP_BYTE    32'h0000_0001
`define EAG_STEP_WORD    32'h0000_0002
`define EAG_STEP_LONG    32'h0000_0004
`define EAG_STEP_NONE    32'h0000_0000
`define EAG_SP_INDEX     3'h7
`define EAG_OPC_WORDS_S  2'h1
`define EAG_OPC_WORDS_L  2'h2
`define EAG_RESULT_ZERO  32'h0000_0000

`endif

// ---- logic/eag_pkg.sv ----
package eag_pkg;

    typedef enum logic [3:0] {
        EAG_MODE_INDIRECT  = 4'h0,
        EAG_MODE_PREDEC    = 4'h1,
        EAG_MODE_POSTINC   = 4'h2,
        EAG_MODE_DISP      = 4'h3,
        EAG_MODE_INDEX     = 4'h4,
        EAG_MODE_ABS_SHORT = 4'h5,
        EAG_MODE_ABS_LONG  = 4'h6,
        EAG_MODE_PC_DISP   = 4'h7,
        EAG_MODE_PC_INDEX  = 4'h8,
        EAG_MODE_BRANCH    = 4'h9,
        EAG_MODE_IMMEDIATE = 4'ha
    } eag_mode_t;

    typedef enum logic [1:0] {
        EAG_SIZE_BYTE = 2'h0,
        EAG_SIZE_WORD = 2'h1,
        EAG_SIZE_LONG = 2'h2
    } eag_size_t;

    typedef enum logic [1:0] {
        EAG_ST_IDLE = 2'h0,
        EAG_ST_DONE = 2'h1
    } eag_state_t;

endpackage

// ---- logic/eag_sext.sv ----
`timescale 1ns/100ps
`include "eag_consts.svh"

module eag_sext (
    input  wire logic [31:0] word_in,
    input  wire logic        use_byte,
    input  wire logic        use_half,
    output logic      [31:0] word_out
);

    always_comb begin
        if (use_byte) begin
            word_out = {{24{word_in[7]}}, word_in[7:0]};
        end else if (use_half) begin
            word_out = {{16{word_in[15]}}, word_in[15:0]};
        end else begin
            word_out = word_in;
        end
    end

endmodule // eag_sext

// ---- logic/eag_effective_address.sv ----
// Behaviour
// - indirect uses register unchanged, no writeback
// - predecrement subtracts size, uses and writes back
// - postincrement uses register, then adds size
// - displacement mode adds sign-extended 16-bit displacement
// - index mode adds register, byte displacement, index
// - word index sign-extended low half; long full
// - absolute short sign-extends 16-bit address word
// - absolute long uses two words unchanged
// - pc displacement base is instruction address plus two
// - pc index adds base, byte displacement, index
// - branches pc-relative with sign-extended 8/16 displacement
// - long branch occupies opcode plus displacement word
// - immediate passes operand value through
// - register seven selects supervisor or user stack
`timescale 1ns/100ps
`include "eag_consts.svh"

module eag_effective_address #(
    parameter int WORD_W = `EAG_WORD_W
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 req_valid,
    input  wire eag_pkg::eag_mode_t   mode,
    input  wire eag_pkg::eag_size_t   op_size,
    input  wire logic [2:0]           base_sel,
    input  wire logic [2:0]           index_sel,
    input  wire logic                 index_is_addr,
    input  wire logic                 index_long_sized,
    input  wire logic                 supervisor_state,
    input  wire logic [15:0]          opcode_word,
    input  wire logic [15:0]          ext_word_hi,
    input  wire logic [15:0]          ext_word_lo,
    input  wire logic [WORD_W-1:0]    instr_addr,
    input  wire logic [WORD_W-1:0]    addr_reg_n_in [0:6],
    input  wire logic [WORD_W-1:0]    data_reg_n_in [0:7],
    input  wire logic [WORD_W-1:0]    supervisor_stack_ptr,
    input  wire logic [WORD_W-1:0]    user_stack_ptr,
    output logic                      res_valid,
    output logic [WORD_W-1:0]         ea_out,
    output logic                      ea_is_operand,
    output logic                      wb_en,
    output logic [2:0]                wb_sel,
    output logic                      wb_to_ssp,
    output logic [WORD_W-1:0]         wb_value,
    output logic [1:0]                opcode_words
);

    eag_pkg::eag_state_t state_reg;
    eag_pkg::eag_state_t state_next;
    logic [WORD_W-1:0]   ea_reg;
    logic [WORD_W-1:0]   ea_next;
    logic                operand_reg;
    logic                operand_next;
    logic                wb_en_reg;
    logic                wb_en_next;
    logic [2:0]          wb_sel_reg;
    logic [2:0]          wb_sel_next;
    logic                wb_ssp_reg;
    logic                wb_ssp_next;
    logic [WORD_W-1:0]   wb_val_reg;
    logic [WORD_W-1:0]   wb_val_next;
    logic [1:0]          words_reg;
    logic [1:0]          words_next;
    logic [WORD_W-1:0]   base_val;
    logic [WORD_W-1:0]   index_raw;
    logic [WORD_W-1:0]   index_val;
    logic [WORD_W-1:0]   disp8;
    logic [WORD_W-1:0]   disp16;
    logic [WORD_W-1:0]   branch8;
    logic [WORD_W-1:0]   pc_base;
    logic [WORD_W-1:0]   step;
    logic                long_branch;

    // register seven aliases the stack pointer of the current state
    function automatic logic [31:0] addr_read(input logic [2:0] sel,
                                              input logic       sup);
        if (sel == `EAG_SP_INDEX) begin
            addr_read = sup ? supervisor_stack_ptr : user_stack_ptr;
        end else begin
            addr_read = addr_reg_n_in[sel];
        end
    endfunction

    // plain 32-bit add: carries out are dropped, no overflow flag
    function automatic logic [31:0] wrap_add(input logic [31:0] a,
                                             input logic [31:0] b);
        wrap_add = a + b;
    endfunction

    // byte displacement sign-extended; shared by index modes and short branch
    function automatic logic [31:0] sext8(input logic [7:0] b);
        sext8 = {{24{b[7]}}, b};
    endfunction

    // word displacement or short address sign-extended
    function automatic logic [31:0] sext16(input logic [15:0] h);
        sext16 = {{16{h[15]}}, h};
    endfunction

    always_comb begin
        base_val  = addr_read(base_sel, supervisor_state);
        index_raw = index_is_addr ? addr_read(index_sel, supervisor_state)
                                  : data_reg_n_in[index_sel];
        pc_base   = wrap_add(instr_addr, `EAG_PC_BASE_OFS);
        long_branch = (opcode_word[7:0] == 8'h00);
        disp8     = sext8(ext_word_hi[7:0]);
        disp16    = sext16(ext_word_hi);
        branch8   = sext8(opcode_word[7:0]);
        case (op_size)
            eag_pkg::EAG_SIZE_BYTE: step = `EAG_STEP_BYTE;
            eag_pkg::EAG_SIZE_WORD: step = `EAG_STEP_WORD;
            eag_pkg::EAG_SIZE_LONG: step = `EAG_STEP_LONG;
            default:                step = `EAG_STEP_NONE;
        endcase
    end

    eag_sext u_idx (
        .word_in  (index_raw),
        .use_byte (1'b0),
        .use_half (~index_long_sized),
        .word_out (index_val)
    );

    always_comb begin
        state_next   = state_reg;
        ea_next      = ea_reg;
        operand_next = operand_reg;
        wb_en_next   = 1'b0;
        wb_sel_next  = wb_sel_reg;
        wb_ssp_next  = wb_ssp_reg;
        wb_val_next  = wb_val_reg;
        words_next   = words_reg;
        case (state_reg)
            eag_pkg::EAG_ST_IDLE,
            eag_pkg::EAG_ST_DONE: begin
                state_next = req_valid ? eag_pkg::EAG_ST_DONE : eag_pkg::EAG_ST_IDLE;
                if (req_valid) begin
                    operand_next = 1'b0;
                    wb_sel_next  = base_sel;
                    wb_ssp_next  = (base_sel == `EAG_SP_INDEX) && supervisor_state;
                    words_next   = `EAG_OPC_WORDS_S;
                    case (mode)
                        eag_pkg::EAG_MODE_INDIRECT: begin
                            ea_next = base_val;
                        end
                        eag_pkg::EAG_MODE_PREDEC: begin
                            ea_next     = base_val - step;
                            wb_en_next  = 1'b1;
                            wb_val_next = base_val - step;
                        end
                        eag_pkg::EAG_MODE_POSTINC: begin
                            ea_next     = base_val;
                            wb_en_next  = 1'b1;
                            wb_val_next = wrap_add(base_val, step);
                        end
                        eag_pkg::EAG_MODE_DISP: begin
                            ea_next = wrap_add(base_val, disp16);
                        end
                        eag_pkg::EAG_MODE_INDEX: begin
                            ea_next = wrap_add(wrap_add(base_val, disp8), index_val);
                        end
                        eag_pkg::EAG_MODE_ABS_SHORT: begin
                            ea_next = disp16;
                        end
                        eag_pkg::EAG_MODE_ABS_LONG: begin
                            ea_next = {ext_word_hi, ext_word_lo};
                        end
                        eag_pkg::EAG_MODE_PC_DISP: begin
                            ea_next = wrap_add(pc_base, disp16);
                        end
                        eag_pkg::EAG_MODE_PC_INDEX: begin
                            ea_next = wrap_add(wrap_add(pc_base, disp8), index_val);
                        end
                        eag_pkg::EAG_MODE_BRANCH: begin
                            // target is always relative to the program counter
                            ea_next = wrap_add(pc_base, long_branch ? disp16 : branch8);
                            words_next = long_branch ? `EAG_OPC_WORDS_L
                                                     : `EAG_OPC_WORDS_S;
                        end
                        eag_pkg::EAG_MODE_IMMEDIATE: begin
                            // value, not an address; byte/word in low word
                            operand_next = 1'b1;
                            case (op_size)
                                eag_pkg::EAG_SIZE_BYTE: ea_next = {24'h000000, ext_word_hi[7:0]};
                                eag_pkg::EAG_SIZE_WORD: ea_next = {16'h0000, ext_word_hi};
                                default:                ea_next = {ext_word_hi, ext_word_lo};
                            endcase
                        end
                        default: begin
                            ea_next = `EAG_RESULT_ZERO;
                        end
                    endcase
                end
            end
            default: begin
                state_next = eag_pkg::EAG_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg   <= eag_pkg::EAG_ST_IDLE;
            ea_reg      <= `EAG_RESULT_ZERO;
            operand_reg <= 1'b0;
            wb_en_reg   <= 1'b0;
            wb_sel_reg  <= 3'h0;
            wb_ssp_reg  <= 1'b0;
            wb_val_reg  <= `EAG_RESULT_ZERO;
            words_reg   <= `EAG_OPC_WORDS_S;
        end else begin
            state_reg   <= state_next;
            ea_reg      <= ea_next;
            operand_reg <= operand_next;
            wb_en_reg   <= wb_en_next;
            wb_sel_reg  <= wb_sel_next;
            wb_ssp_reg  <= wb_ssp_next;
            wb_val_reg  <= wb_val_next;
            words_reg   <= words_next;
        end
    end

    // odd word addresses are not trapped; software keeps them even
    assign res_valid     = (state_reg == eag_pkg::EAG_ST_DONE);
    assign ea_out        = ea_reg;
    assign ea_is_operand = operand_reg;
    assign wb_en         = wb_en_reg;
    assign wb_sel        = wb_sel_reg;
    assign wb_to_ssp     = wb_ssp_reg;
    assign wb_value      = wb_val_reg;
    assign opcode_words  = words_reg;

endmodule // eag_effective_address

// ---- bench/eag_regfile_model.sv ----
`timescale 1ns/100ps
module eag_regfile_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        wb_en,
    input  wire logic [2:0]  wb_sel,
    input  wire logic        wb_to_ssp,
    input  wire logic [31:0] wb_value,
    output logic      [31:0] addr_reg_n_in [0:6],
    output logic      [31:0] data_reg_n_in [0:7],
    output logic      [31:0] supervisor_stack_ptr,
    output logic      [31:0] user_stack_ptr
);
    // address and stack seeds stay even so word and long operands are aligned
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int n = 0; n < 8; n++) begin
                data_reg_n_in[n] <= 32'h0001_8000 + 32'(n);
            end
            for (int n = 0; n < 7; n++) begin
                addr_reg_n_in[n] <= 32'(n) << 12;
            end
            supervisor_stack_ptr <= 32'h0000_8000;
            user_stack_ptr <= 32'h0000_4000;
        end else if (wb_en && wb_sel != 3'h7) begin
            addr_reg_n_in[wb_sel] <= wb_value;
        end else if (wb_en) begin
            // write lands a cycle late: the next request must not come sooner
            if (wb_to_ssp) supervisor_stack_ptr <= wb_value;
            else user_stack_ptr <= wb_value;
        end
    end
endmodule // eag_regfile_model

// ---- bench/eag_checker.sv ----
`timescale 1ns/100ps
module eag_checker #(
    parameter int WORD_W = 32
) (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               req_valid,
    input wire eag_pkg::eag_mode_t mode,
    input wire eag_pkg::eag_size_t op_size,
    input wire logic [2:0]         base_sel,
    input wire logic               supervisor_state,
    input wire logic [15:0]        opcode_word,
    input wire logic [15:0]        ext_word_hi,
    input wire logic [15:0]        ext_word_lo,
    input wire logic [WORD_W-1:0]  instr_addr,
    input wire logic [WORD_W-1:0]  addr_reg_n_in [0:6],
    input wire logic [WORD_W-1:0]  supervisor_stack_ptr,
    input wire logic [WORD_W-1:0]  user_stack_ptr,
    input wire logic               res_valid,
    input wire logic [WORD_W-1:0]  ea_out,
    input wire logic               ea_is_operand,
    input wire logic               wb_en,
    input wire logic [WORD_W-1:0]  wb_value,
    input wire logic [1:0]         opcode_words
);
    logic [WORD_W-1:0] stk;
    logic [WORD_W-1:0] base_val;
    logic [WORD_W-1:0] step_val;
    logic [WORD_W-1:0] disp16;
    assign stk = supervisor_state ? supervisor_stack_ptr : user_stack_ptr;
    assign base_val = (base_sel == 3'h7) ? stk : addr_reg_n_in[base_sel];
    assign step_val = (op_size == eag_pkg::EAG_SIZE_LONG) ? 32'h4 :
                      (op_size == eag_pkg::EAG_SIZE_WORD) ? 32'h2 : 32'h1;
    assign disp16 = {{16{ext_word_hi[15]}}, ext_word_hi};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence go(eag_pkg::eag_mode_t m);
        req_valid && mode == m;
    endsequence
    valid_lat_a: assert property (req_valid |=> res_valid)
        else $error("result strobe missing");
    indir_addr_a: assert property (go(eag_pkg::EAG_MODE_INDIRECT) |=> ea_out == $past(base_val) && !wb_en)
        else $error("indirect address wrong");
    predec_step_a: assert property (go(eag_pkg::EAG_MODE_PREDEC) |=> wb_en && ea_out == $past(base_val - step_val) && wb_value == ea_out)
        else $error("predecrement wrong");
    postinc_step_a: assert property (go(eag_pkg::EAG_MODE_POSTINC) |=> wb_en && ea_out == $past(base_val) && wb_value == $past(base_val + step_val))
        else $error("postincrement wrong");
    disp_sum_a: assert property (go(eag_pkg::EAG_MODE_DISP) |=> ea_out == $past(base_val + disp16))
        else $error("displacement sum wrong");
    abs_short_a: assert property (go(eag_pkg::EAG_MODE_ABS_SHORT) |=> ea_out == $past(disp16))
        else $error("absolute short wrong");
    abs_long_a: assert property (go(eag_pkg::EAG_MODE_ABS_LONG) |=> ea_out == $past({ext_word_hi, ext_word_lo}))
        else $error("absolute long wrong");
    pc_disp_a: assert property (go(eag_pkg::EAG_MODE_PC_DISP) |=> ea_out == $past(instr_addr + 32'h2 + disp16))
        else $error("pc displacement wrong");
    br_long_a: assert property (go(eag_pkg::EAG_MODE_BRANCH) ##0 opcode_word[7:0] == 8'h0 |=> opcode_words == 2'h2 && ea_out == $past(instr_addr + 32'h2 + disp16))
        else $error("long branch wrong");
    imm_long_a: assert property (go(eag_pkg::EAG_MODE_IMMEDIATE) ##0 op_size == eag_pkg::EAG_SIZE_LONG |=> ea_is_operand && ea_out == $past({ext_word_hi, ext_word_lo}))
        else $error("immediate wrong");
    predec_c: cover property (go(eag_pkg::EAG_MODE_PREDEC));
    index_c: cover property (go(eag_pkg::EAG_MODE_PC_INDEX));
    branch_c: cover property (go(eag_pkg::EAG_MODE_BRANCH));
endmodule // eag_checker
bind eag_effective_address eag_checker #(.WORD_W(WORD_W)) i_eag_checker (.*);

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    tests_run++; \
    if ((got) !== (ex)) begin \
        n_mismatch++; \
        $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end
module testbench;
    logic               clock = 1'b0;
    logic               rst = 1'b1;
    logic               req_valid = 1'b0;
    eag_pkg::eag_mode_t mode = eag_pkg::EAG_MODE_INDIRECT;
    eag_pkg::eag_size_t op_size = eag_pkg::EAG_SIZE_WORD;
    logic [2:0]         base_sel = 3'h0, index_sel = 3'h0, wb_sel;
    logic               index_is_addr = 1'b0, index_long_sized = 1'b0, supervisor_state = 1'b0;
    logic [15:0]        opcode_word = 16'h0, ext_word_hi = 16'h0, ext_word_lo = 16'h0;
    logic [31:0]        instr_addr = 32'h0, ea_out, wb_value, supervisor_stack_ptr, user_stack_ptr;
    logic [31:0]        addr_reg_n_in [0:6];
    logic [31:0]        data_reg_n_in [0:7];
    logic               res_valid, ea_is_operand, wb_en, wb_to_ssp;
    logic [1:0]         opcode_words;
    int                 n_mismatch = 0, tests_run = 0, cycles = 0;
    eag_effective_address i_eag_effective_address (.*);
    eag_regfile_model i_eag_regfile_model (.*);
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ix packs supervisor, index number, index from address regs, long index
    task automatic req(input eag_pkg::eag_mode_t m, input logic [2:0] b, input logic [15:0] hi,
        input eag_pkg::eag_size_t s = eag_pkg::EAG_SIZE_WORD, input logic [15:0] lo = 16'h0,
        input logic [5:0] ix = 6'h0, input logic [15:0] opc = 16'h0, input logic [31:0] pc = 32'h0);
        @(posedge clock);
        req_valid <= 1'b1;
        mode <= m;
        op_size <= s;
        {base_sel, ext_word_hi, ext_word_lo, opcode_word, instr_addr} <= {b, hi, lo, opc, pc};
        {supervisor_state, index_sel, index_is_addr, index_long_sized} <= ix;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        `CHK("res_valid", 1'b1, res_valid)
    endtask
    task automatic t_regs();
        req(eag_pkg::EAG_MODE_INDIRECT, 3'h3, 16'h0);
        `CHK("indirect", 32'h0000_3000, ea_out)
        `CHK("wb_en", 1'b0, wb_en)
        req(eag_pkg::EAG_MODE_INDIRECT, 3'h7, 16'h0, .ix(6'h20));
        `CHK("stack alias", 32'h0000_8000, ea_out)
        req(eag_pkg::EAG_MODE_PREDEC, 3'h0, 16'h0, eag_pkg::EAG_SIZE_BYTE);
        `CHK("predec wrap", 32'hffff_ffff, wb_value)
        req(eag_pkg::EAG_MODE_PREDEC, 3'h7, 16'h0, eag_pkg::EAG_SIZE_LONG, .ix(6'h20));
        `CHK("predec long", 32'h0000_7ffc, ea_out)
        `CHK("wb_to_ssp", 1'b1, wb_to_ssp)
        req(eag_pkg::EAG_MODE_POSTINC, 3'h4, 16'h0, eag_pkg::EAG_SIZE_LONG);
        `CHK("postinc wb", 32'h0000_4004, wb_value)
        req(eag_pkg::EAG_MODE_POSTINC, 3'h4, 16'h0);
        `CHK("postinc again", 32'h0000_4004, ea_out)
        $display("test regs done");
    endtask
    task automatic t_offsets();
        req(eag_pkg::EAG_MODE_DISP, 3'h1, 16'hfff0);
        `CHK("disp", 32'h0000_0ff0, ea_out)
        req(eag_pkg::EAG_MODE_INDEX, 3'h1, 16'h0080, .ix(6'h08));
        `CHK("word index", 32'hffff_8f82, ea_out)
        req(eag_pkg::EAG_MODE_INDEX, 3'h1, 16'h0080, .ix(6'h09));
        `CHK("long index", 32'h0001_8f82, ea_out)
        req(eag_pkg::EAG_MODE_PC_INDEX, 3'h0, 16'h00ae, .ix(6'h16), .pc(32'h0000_1150));
        `CHK("pc index", 32'h0000_6100, ea_out)
        req(eag_pkg::EAG_MODE_PC_DISP, 3'h0, 16'hf8ae, .pc(32'h0000_1050));
        `CHK("pc disp", 32'h0000_0900, ea_out)
        $display("test offsets done");
    endtask
    task automatic t_special();
        req(eag_pkg::EAG_MODE_ABS_SHORT, 3'h0, 16'h8000);
        `CHK("abs short", 32'hffff_8000, ea_out)
        req(eag_pkg::EAG_MODE_ABS_LONG, 3'h0, 16'h0001, .lo(16'h2000));
        `CHK("abs long", 32'h0001_2000, ea_out)
        req(eag_pkg::EAG_MODE_BRANCH, 3'h0, 16'hffae, .opc(16'h6700), .pc(32'h0000_1050));
        `CHK("long branch", 32'h0000_1000, ea_out)
        `CHK("branch words", 2'h2, opcode_words)
        req(eag_pkg::EAG_MODE_BRANCH, 3'h0, 16'h0000, .opc(16'h6e0e), .pc(32'h0000_1050));
        `CHK("short branch", 32'h0000_1060, ea_out)
        req(eag_pkg::EAG_MODE_IMMEDIATE, 3'h0, 16'h12ab, eag_pkg::EAG_SIZE_BYTE);
        `CHK("immediate", 33'h1_0000_00ab, {ea_is_operand, ea_out})
        $display("test special done");
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_offsets();
        t_special();
        finish_test();
    end
endmodule // testbench
